// ---- inc/spms_pkg.sv ----
package spms_pkg;
    // register byte offsets on the bus
    localparam logic [3:0] OFF_DATA        = 4'h0;
    localparam logic [3:0] OFF_CTRL        = 4'h4;
    localparam logic [3:0] OFF_STAT        = 4'h8;
    // serial_control field positions
    localparam int         CTL_IRQ_EN      = 7;
    localparam int         CTL_PORT_EN     = 6;
    localparam int         CTL_DIV_HI      = 5;
    localparam int         CTL_MASTER      = 4;
    localparam int         CTL_CLOCK_POLARITY        = 3;
    localparam int         CTL_CLOCK_PHASE        = 2;
    localparam int         CTL_DIV_LO      = 0;
    localparam logic [7:0] CTL_RESET       = 8'h00;
    localparam logic [7:0] STAT_RESET      = 8'h00;
    // half periods of sck in clock cycles, per divide ratio
    localparam logic [6:0] HALF_DIV4       = 7'h02;
    localparam logic [6:0] HALF_DIV8       = 7'h04;
    localparam logic [6:0] HALF_DIV16      = 7'h08;
    localparam logic [6:0] HALF_DIV32      = 7'h10;
    localparam logic [6:0] HALF_DIV64      = 7'h20;
    localparam logic [6:0] HALF_DIV128     = 7'h40;
    // sixteen sck transitions make one byte
    localparam logic [3:0] LAST_EDGE       = 4'hf;
    localparam logic [1:0] RESP_OKAY       = 2'h0;
    localparam logic [1:0] RESP_SLVERR     = 2'h2;

    typedef enum logic {
        SPMS_IDLE  = 1'b0,
        SPMS_SHIFT = 1'b1
    } spms_xfer_e;

    typedef struct packed {
        logic sck;
        logic mosi;
        logic miso;
        logic ss_n;
    } spms_pin_in_s;

    typedef struct packed {
        logic sck_o;
        logic sck_oe;
        logic mosi_o;
        logic mosi_oe;
        logic miso_o;
        logic miso_oe;
    } spms_pin_out_s;

    typedef struct packed {
        logic          awready;
        logic          aw_ok;
        logic [3:0]    aw_addr;
        logic          wready;
        logic          w_ok;
        logic [7:0]    w_data;
        logic          w_lane0;
        logic          bvalid;
        logic [1:0]    bresp;
        logic          arready;
        logic          rvalid;
        logic [7:0]    rdata;
        logic [1:0]    rresp;
        logic [7:0]    serial_control;
        logic          transfer_done_flag;
        logic          write_collision_flag;
        logic          overrun_flag;
        logic          mode_fault_flag;
        logic          output_disable;
        logic          select_soft_manage;
        logic          select_internal_level;
        logic          done_seq;
        logic          fault_seq;
        spms_xfer_e    xf;
        logic [7:0]    shifter;
        logic [7:0]    serial_data_buffer;
        logic          dout;
        logic          sck;
        logic [3:0]    edge_cnt;
        logic [6:0]    div_cnt;
        logic [1:0]    sck_sync;
        logic [1:0]    mosi_sync;
        logic [1:0]    miso_sync;
        logic [1:0]    ss_sync;
        logic          sck_prev;
        logic          halt_prev;
        logic          halt_armed;
        logic          irq;
        logic          wake;
        spms_pin_out_s pins;
    } spms_state_s;
endpackage

// ---- core/spms_top.sv ----
// The AXI4-Lite interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module spms_top (
    input  wire logic                    aclk,
    input  wire logic                    aresetn,
    input  wire logic                    s_axi_awvalid,
    output logic                         s_axi_awready,
    input  wire logic [3:0]              s_axi_awaddr,
    input  wire logic                    s_axi_wvalid,
    output logic                         s_axi_wready,
    input  wire logic [31:0]             s_axi_wdata,
    input  wire logic [3:0]              s_axi_wstrb,
    output logic                         s_axi_bvalid,
    input  wire logic                    s_axi_bready,
    output logic [1:0]                   s_axi_bresp,
    input  wire logic                    s_axi_arvalid,
    output logic                         s_axi_arready,
    input  wire logic [3:0]              s_axi_araddr,
    output logic                         s_axi_rvalid,
    input  wire logic                    s_axi_rready,
    output logic [31:0]                  s_axi_rdata,
    output logic [1:0]                   s_axi_rresp,
    input  wire spms_pkg::spms_pin_in_s  pin_in,
    output spms_pkg::spms_pin_out_s      pin_out,
    input  wire logic                    halt_mode,
    output logic                         irq,
    output logic                         halt_wake
);

    spms_pkg::spms_state_s st;
    spms_pkg::spms_state_s next_st;

    // half period of the master sck for the divide bits
    function automatic logic [6:0] half_period(input logic hi, input logic [1:0] lo);
        logic [6:0] h;
        h = spms_pkg::HALF_DIV128;
        unique case ({hi, lo})
            3'b100: h = spms_pkg::HALF_DIV4;
            3'b000: h = spms_pkg::HALF_DIV8;
            3'b001: h = spms_pkg::HALF_DIV16;
            3'b110: h = spms_pkg::HALF_DIV32;
            3'b010: h = spms_pkg::HALF_DIV64;
            default: h = spms_pkg::HALF_DIV128; // codes with no listed ratio run slowest
        endcase
        return h;
    endfunction

    // byte offset decode, shared by the read and write paths
    function automatic logic is_reg(input logic [3:0] a, input logic [3:0] off);
        return a == off;
    endfunction

    // outputs straight from the state flops
    assign s_axi_awready = st.awready;
    assign s_axi_wready  = st.wready;
    assign s_axi_bvalid  = st.bvalid;
    assign s_axi_bresp   = st.bresp;
    assign s_axi_arready = st.arready;
    assign s_axi_rvalid  = st.rvalid;
    assign s_axi_rdata   = {24'h000000, st.rdata};
    assign s_axi_rresp   = st.rresp;
    assign pin_out       = st.pins;
    assign irq           = st.irq;
    assign halt_wake     = st.wake;

    // next state: bus side first, then pin events so a set beats a clear
    always_comb begin
        logic       wr_go;
        logic       rd_go;
        logic       ss_low;
        logic       busy;
        logic       is_master;
        logic       enabled;
        logic       edge_ev;
        logic       slave_ok;
        logic [7:0] shifted;
        wr_go     = 1'b0;
        rd_go     = 1'b0;
        ss_low    = 1'b0;
        busy      = 1'b0;
        is_master = 1'b0;
        enabled   = 1'b0;
        edge_ev   = 1'b0;
        slave_ok  = 1'b0;
        shifted   = 8'h00;
        next_st   = st;

        // pin synchronisers; only stage one feeds stage two
        next_st.sck_sync  = {st.sck_sync[0], pin_in.sck};
        next_st.mosi_sync = {st.mosi_sync[0], pin_in.mosi};
        next_st.miso_sync = {st.miso_sync[0], pin_in.miso};
        next_st.ss_sync   = {st.ss_sync[0], pin_in.ss_n};
        next_st.sck_prev  = st.sck_sync[1];
        next_st.halt_prev = halt_mode;

        // soft select replaces the pin when managed internally
        ss_low = st.select_soft_manage ? ~st.select_internal_level : ~st.ss_sync[1];
        busy   = (st.xf == spms_pkg::SPMS_SHIFT) || (st.edge_cnt != 4'h0);

        // write address and data are taken independently
        if (s_axi_awvalid && st.awready) begin
            next_st.aw_ok   = 1'b1;
            next_st.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && st.wready) begin
            next_st.w_ok    = 1'b1;
            next_st.w_data  = s_axi_wdata[7:0];
            next_st.w_lane0 = s_axi_wstrb[0];
        end
        if (st.bvalid && s_axi_bready) begin
            next_st.bvalid = 1'b0;
        end
        wr_go = st.aw_ok && st.w_ok && !st.bvalid;
        if (wr_go) begin
            next_st.aw_ok  = 1'b0;
            next_st.w_ok   = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp  = spms_pkg::RESP_OKAY;
            if (is_reg(st.aw_addr, spms_pkg::OFF_CTRL)) begin
                if (st.w_lane0) begin
                    next_st.serial_control = st.w_data;
                    if (st.mode_fault_flag && st.fault_seq) begin
                        next_st.mode_fault_flag = 1'b0;
                        next_st.fault_seq       = 1'b0;
                    end else if (st.mode_fault_flag) begin
                        next_st.serial_control[spms_pkg::CTL_PORT_EN] = 1'b0;
                        next_st.serial_control[spms_pkg::CTL_MASTER]  = 1'b0;
                    end
                end
            end else if (is_reg(st.aw_addr, spms_pkg::OFF_STAT)) begin
                if (st.w_lane0) begin
                    next_st.output_disable        = st.w_data[2];
                    next_st.select_soft_manage    = st.w_data[1];
                    next_st.select_internal_level = st.w_data[0];
                end
                // a write is a status access too
                if (st.transfer_done_flag || st.write_collision_flag) begin
                    next_st.done_seq = 1'b1;
                end
                if (st.mode_fault_flag) begin
                    next_st.fault_seq = 1'b1;
                end
            end else if (is_reg(st.aw_addr, spms_pkg::OFF_DATA)) begin
                if (st.w_lane0 && !(st.transfer_done_flag && !st.done_seq)) begin
                    if (st.done_seq) begin
                        next_st.transfer_done_flag   = 1'b0;
                        next_st.write_collision_flag = 1'b0;
                        next_st.done_seq             = 1'b0;
                    end
                    if (busy) begin
                        next_st.write_collision_flag = 1'b1;
                    end else begin
                        next_st.shifter = st.w_data;
                        next_st.dout    = st.w_data[7];
                        if (st.serial_control[spms_pkg::CTL_PORT_EN] && st.serial_control[spms_pkg::CTL_MASTER]
                            && !halt_mode) begin
                            next_st.xf       = spms_pkg::SPMS_SHIFT;
                            next_st.edge_cnt = 4'h0;
                            next_st.div_cnt  = half_period(st.serial_control[spms_pkg::CTL_DIV_HI],
                                                           st.serial_control[1:0]) - 7'h01;
                        end
                    end
                end
            end else begin
                next_st.bresp = spms_pkg::RESP_SLVERR;
            end
        end

        // read: answered the cycle after the address is taken
        if (st.rvalid && s_axi_rready) begin
            next_st.rvalid = 1'b0;
        end
        rd_go = s_axi_arvalid && st.arready;
        if (rd_go) begin
            next_st.rvalid = 1'b1;
            next_st.rresp  = spms_pkg::RESP_OKAY;
            next_st.rdata  = 8'h00;
            if (is_reg(s_axi_araddr, spms_pkg::OFF_CTRL)) begin
                next_st.rdata = st.serial_control;
            end else if (is_reg(s_axi_araddr, spms_pkg::OFF_STAT)) begin
                next_st.rdata = {st.transfer_done_flag, st.write_collision_flag, st.overrun_flag,
                                 st.mode_fault_flag, 1'b0, st.output_disable, st.select_soft_manage,
                                 st.select_internal_level};
                next_st.overrun_flag = 1'b0;
                if (st.transfer_done_flag || st.write_collision_flag) begin
                    next_st.done_seq = 1'b1;
                end
                if (st.mode_fault_flag) begin
                    next_st.fault_seq = 1'b1;
                end
            end else if (is_reg(s_axi_araddr, spms_pkg::OFF_DATA)) begin
                next_st.rdata = st.serial_data_buffer;
                if (st.done_seq) begin
                    next_st.transfer_done_flag   = 1'b0;
                    next_st.write_collision_flag = 1'b0;
                    next_st.done_seq             = 1'b0;
                end
            end else begin
                next_st.rresp = spms_pkg::RESP_SLVERR;
            end
        end

        // halt: arm a slave wake only if selected at entry
        if (halt_mode && !st.halt_prev) begin
            next_st.halt_armed = ss_low && st.serial_control[spms_pkg::CTL_PORT_EN]
                                 && !st.serial_control[spms_pkg::CTL_MASTER];
        end
        if (!halt_mode) begin
            next_st.halt_armed = 1'b0;
        end

        is_master = next_st.serial_control[spms_pkg::CTL_MASTER];
        enabled   = next_st.serial_control[spms_pkg::CTL_PORT_EN];

        // mode fault: select pulled low while we are the master
        if (enabled && is_master && ss_low && !halt_mode) begin
            next_st.mode_fault_flag = 1'b1;
            next_st.serial_control[spms_pkg::CTL_PORT_EN] = 1'b0;
            next_st.serial_control[spms_pkg::CTL_MASTER]  = 1'b0;
            next_st.xf       = spms_pkg::SPMS_IDLE;
            next_st.edge_cnt = 4'h0;
            enabled          = 1'b0;
            is_master        = 1'b0;
        end

        // master ticks from the divider; frozen in halt
        if (is_master && enabled && st.xf == spms_pkg::SPMS_SHIFT && !halt_mode) begin
            if (st.div_cnt == 7'h00) begin
                edge_ev         = 1'b1;
                next_st.div_cnt = half_period(st.serial_control[spms_pkg::CTL_DIV_HI],
                                              st.serial_control[1:0]) - 7'h01;
            end else begin
                next_st.div_cnt = st.div_cnt - 7'h01;
            end
        end
        // slave follows synchronised sck; divide bits unused here
        slave_ok = enabled && !is_master && ss_low && (!halt_mode || st.halt_armed);
        if (slave_ok && (st.sck_sync[1] != st.sck_prev)) begin
            edge_ev = 1'b1;
        end
        if (enabled && !is_master && !ss_low) begin
            next_st.edge_cnt = 4'h0;                              // deselect ends a partial byte
        end

        // shared shift engine: capture on edges matching the phase
        if (edge_ev) begin
            if (st.edge_cnt[0] == st.serial_control[spms_pkg::CTL_CLOCK_PHASE]) begin
                shifted = {st.shifter[6:0], is_master ? st.miso_sync[1] : st.mosi_sync[1]};
                next_st.shifter = shifted;
            end else begin
                shifted      = st.shifter;
                next_st.dout = st.shifter[7];
            end
            if (is_master) begin
                next_st.sck = ~st.sck;
            end
            next_st.edge_cnt = st.edge_cnt + 4'h1;
            if (st.edge_cnt == spms_pkg::LAST_EDGE) begin
                next_st.edge_cnt = 4'h0;
                next_st.xf       = spms_pkg::SPMS_IDLE;
                // a done clear in this same cycle lets the new byte set the flag again
                if (next_st.transfer_done_flag) begin
                    next_st.overrun_flag = 1'b1;
                end else begin
                    next_st.transfer_done_flag = 1'b1;
                    next_st.serial_data_buffer = shifted;
                end
            end
        end

        // sck rests at the polarity level between bytes
        if (next_st.xf == spms_pkg::SPMS_IDLE) begin
            next_st.sck = next_st.serial_control[spms_pkg::CTL_CLOCK_POLARITY];
        end

        // pin drive: nothing unless the port is enabled
        enabled   = next_st.serial_control[spms_pkg::CTL_PORT_EN];
        is_master = next_st.serial_control[spms_pkg::CTL_MASTER];
        next_st.pins.sck_o   = next_st.sck;
        next_st.pins.sck_oe  = enabled && is_master;
        next_st.pins.mosi_o  = next_st.dout;
        next_st.pins.mosi_oe = enabled && is_master && !next_st.output_disable;
        next_st.pins.miso_o  = next_st.dout;
        next_st.pins.miso_oe = enabled && !is_master && !next_st.output_disable && ss_low;

        // one shared request; it also ends wait mode
        next_st.irq  = next_st.serial_control[spms_pkg::CTL_IRQ_EN]
                       && (next_st.transfer_done_flag || next_st.mode_fault_flag
                           || next_st.overrun_flag);
        // only the done event of an armed slave leaves halt
        next_st.wake = halt_mode && next_st.halt_armed && next_st.serial_control[spms_pkg::CTL_IRQ_EN]
                       && next_st.transfer_done_flag;

        // bus readiness follows the pending work
        next_st.awready = !next_st.aw_ok && !next_st.bvalid;
        next_st.wready  = !next_st.w_ok && !next_st.bvalid;
        next_st.arready = !next_st.rvalid;
    end

    // single register bank; synchronous reset to all zero
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

endmodule

// ---- tb/spms_checker.sv ----
`timescale 1ns/1ps
module spms_checker (
    input wire logic                    aclk,
    input wire logic                    aresetn,
    input wire logic                    s_axi_bvalid,
    input wire logic                    s_axi_bready,
    input wire logic                    s_axi_arvalid,
    input wire logic                    s_axi_arready,
    input wire logic [3:0]              s_axi_araddr,
    input wire logic                    s_axi_rvalid,
    input wire logic                    s_axi_rready,
    input wire logic [31:0]             s_axi_rdata,
    input wire logic [1:0]              s_axi_rresp,
    input wire spms_pkg::spms_pin_out_s pin_out,
    input wire logic                    halt_mode,
    input wire logic                    halt_wake
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // reset itself is the cause here, so this one is never disabled
    chk_reset_quiet: assert property (disable iff (1'b0) !aresetn |=>
        !pin_out.sck_oe && !pin_out.mosi_oe && !pin_out.miso_oe) else $error("pins driven after reset");
    chk_pin_dirs: assert property (pin_out.sck_oe |-> !pin_out.miso_oe)
        else $error("master drives miso");
    // fastest divide gives two cycles per level; oe drop may reset the level
    chk_sck_half_min: assert property (pin_out.sck_oe && $past(pin_out.sck_oe) && $changed(pin_out.sck_o)
        |=> !pin_out.sck_oe || $stable(pin_out.sck_o)) else $error("sck level too short");
    chk_halt_frozen: assert property (halt_mode && $past(halt_mode) |-> $stable(pin_out.sck_o))
        else $error("sck moves in halt");
    // wake is registered, so allow one cycle after leaving halt
    chk_wake_in_halt: assert property (!halt_mode && !$past(halt_mode) |-> !halt_wake)
        else $error("wake outside halt");
    chk_b_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("bvalid dropped early");
    chk_r_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer moved");
    chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    chk_unmapped_err: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 4'hc
        |=> s_axi_rresp == spms_pkg::RESP_SLVERR && s_axi_rdata == 32'h0) else $error("unmapped not refused");
    cover property (s_axi_bvalid && s_axi_bready);
    cover property (halt_mode && pin_out.sck_oe);
    cover property (halt_mode && halt_wake);
    cover property (s_axi_rvalid && s_axi_rresp == spms_pkg::RESP_SLVERR);
endmodule

bind spms_top spms_checker u_chk (.aclk(aclk), .aresetn(aresetn), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .pin_out(pin_out), .halt_mode(halt_mode),
    .halt_wake(halt_wake));

// ---- tb/spms_slave_model.sv ----
`timescale 1ns/1ps
// far-end slave, polarity 0 and phase 0 only
module spms_slave_model (
    input  wire logic       sck,
    input  wire logic       mosi,
    input  wire logic       sel_n,
    input  wire logic       load,
    input  wire logic [7:0] tx_byte,
    output logic            miso,
    output logic [7:0]      rx_byte
);
    logic [7:0] sh;
    // byte placed before the first clock of a transfer
    always @(posedge load) sh = tx_byte;
    // capture on the rising edge, first of each bit, msb first
    always @(posedge sck) if (!sel_n) rx_byte = {rx_byte[6:0], mosi};
    // vacated bits toggle so stale data cannot pass for real data
    always @(negedge sck) if (!sel_n) sh = {sh[6:0], ~sh[0]};
    // only one slave on this bus; deselected it shows the inverted last bit
    assign miso = sel_n ? ~sh[7] : sh[7];
endmodule

// ---- tb/testbench.sv ----
`timescale 1ns/1ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin fail_count++; \
    $display("mismatch t=%0t got %h exp %h", $time, a, e); end end
module testbench;
    logic                    aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, ss_n, halt_mode, load;
    logic                    ext_sck, ext_mosi;
    logic                    awready, wready, bvalid, arready, rvalid, irq, halt_wake, sck_w, mosi_w, miso_w, peer_miso;
    logic [3:0]              awaddr, araddr;
    logic [31:0]             wdata, rdata;
    logic [1:0]              bresp, rresp, resp;
    logic [7:0]              rx_byte, got;
    int                      fail_count, compares, cycles;
    spms_pkg::spms_pin_out_s pin_out;
    // a released miso line is driven by the peer slave
    // a far master drives sck and mosi whenever the block does not
    assign sck_w  = pin_out.sck_oe ? pin_out.sck_o : ext_sck;
    assign mosi_w = pin_out.mosi_oe ? pin_out.mosi_o : ext_mosi;
    assign miso_w = pin_out.miso_oe ? pin_out.miso_o : peer_miso;
    spms_top DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .pin_in({sck_w, mosi_w, miso_w, ss_n}),
        .pin_out(pin_out), .halt_mode(halt_mode), .irq(irq), .halt_wake(halt_wake));
    spms_slave_model PEER (.sck(sck_w), .mosi(mosi_w), .sel_n(1'b0), .load(load), .tx_byte(8'h3c),
        .miso(peer_miso), .rx_byte(rx_byte));
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    // address and data offered together, each dropped when taken
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge aclk);
        awaddr  <= a;
        wdata   <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        d = rdata[7:0];
        resp = rresp;
        rready <= 1'b0;
    endtask
    task automatic t_reset;
        rd(spms_pkg::OFF_CTRL, got);
        `CHK(got, spms_pkg::CTL_RESET)
        rd(spms_pkg::OFF_STAT, got);
        `CHK(got, spms_pkg::STAT_RESET)
        `CHK({pin_out.sck_oe, pin_out.mosi_oe, pin_out.miso_oe}, 3'h0)
        rd(4'hc, got);
        `CHK(resp, spms_pkg::RESP_SLVERR)
    endtask
    // soft select ignores the low pin; a collision and a halt land mid-byte
    task automatic t_master;
        wr(spms_pkg::OFF_STAT, 8'h03);
        ss_n <= 1'b0;
        wr(spms_pkg::OFF_CTRL, 8'hd0);
        `CHK({pin_out.sck_oe, pin_out.mosi_oe, pin_out.miso_oe}, 3'h6)
        load <= 1'b1;
        wr(spms_pkg::OFF_DATA, 8'ha5);
        load <= 1'b0;
        wr(spms_pkg::OFF_DATA, 8'h5a);
        halt_mode <= 1'b1;
        repeat (20) @(posedge aclk);
        halt_mode <= 1'b0;
        do @(posedge aclk); while (irq !== 1'b1);
        `CHK(rx_byte, 8'ha5)
        wr(spms_pkg::OFF_DATA, 8'h11);
        repeat (6) @(posedge aclk);
        `CHK(pin_out.sck_o, 1'b0)
        rd(spms_pkg::OFF_STAT, got);
        `CHK(got, 8'hc3)
        `CHK(irq, 1'b1)
        rd(spms_pkg::OFF_DATA, got);
        `CHK(got, 8'h3c)
        rd(spms_pkg::OFF_STAT, got);
        `CHK(got, 8'h03)
        `CHK(irq, 1'b0)
    endtask
    // half period counted between two sck changes for one code of each ratio
    task automatic t_divider;
        logic [2:0] code [6] = '{3'h4, 3'h0, 3'h1, 3'h6, 3'h2, 3'h3};
        int         n;
        logic       s;
        for (int i = 0; i < 6; i++) begin
            wr(spms_pkg::OFF_CTRL, 8'hd0 | {2'h0, code[i][2], 3'h0, code[i][1:0]});
            wr(spms_pkg::OFF_DATA, 8'h00);
            s = pin_out.sck_o;
            while (pin_out.sck_o === s) @(posedge aclk);
            s = pin_out.sck_o;
            n = 0;
            while (pin_out.sck_o === s) begin
                @(posedge aclk);
                n++;
            end
            `CHK(n, 2 << i)
            do @(posedge aclk); while (irq !== 1'b1);
            rd(spms_pkg::OFF_STAT, got);
            rd(spms_pkg::OFF_DATA, got);
        end
    endtask
    task automatic t_fault;
        ss_n <= 1'b1;
        wr(spms_pkg::OFF_CTRL, 8'h00);
        wr(spms_pkg::OFF_STAT, 8'h00);
        wr(spms_pkg::OFF_CTRL, 8'hd0);
        ss_n <= 1'b0;
        repeat (8) @(posedge aclk);
        rd(spms_pkg::OFF_CTRL, got);
        `CHK(got, 8'h80)
        `CHK(pin_out.sck_oe, 1'b0)
        rd(spms_pkg::OFF_STAT, got);
        `CHK(got, 8'h10)
        `CHK(irq, 1'b1)
        ss_n <= 1'b1;
        wr(spms_pkg::OFF_CTRL, 8'h00);
        rd(spms_pkg::OFF_STAT, got);
        `CHK(got, 8'h00)
    endtask
    // far master clocks one byte in, phase 0: data settles before each rising edge
    task automatic send_byte(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            ext_mosi <= b[i];
            repeat (4) @(posedge aclk);
            ext_sck <= 1'b1;
            repeat (4) @(posedge aclk);
            ext_sck <= 1'b0;
        end
        repeat (4) @(posedge aclk);
    endtask
    // armed slave wakes from halt; two bytes in halt overrun; one extra byte after
    task automatic t_slave;
        ss_n <= 1'b0;
        wr(spms_pkg::OFF_CTRL, 8'hc0);
        halt_mode <= 1'b1;
        @(posedge aclk);
        send_byte(8'h96);
        send_byte(8'h69);
        `CHK(halt_wake, 1'b1)
        halt_mode <= 1'b0;
        repeat (2) @(posedge aclk);
        `CHK(halt_wake, 1'b0)
        rd(spms_pkg::OFF_STAT, got);
        `CHK(got, 8'ha0)
        rd(spms_pkg::OFF_DATA, got);
        `CHK(got, 8'h96)
        send_byte(8'h5a);
        rd(spms_pkg::OFF_STAT, got);
        `CHK(got, 8'h80)
        rd(spms_pkg::OFF_DATA, got);
        `CHK(got, 8'h5a)
        ss_n <= 1'b1;
        wr(spms_pkg::OFF_CTRL, 8'h00);
        wr(spms_pkg::OFF_CTRL, 8'h58);
        `CHK(pin_out.sck_o, 1'b1)
    endtask
    task automatic finish_test;
        $display("mismatches %0d comparisons %0d", fail_count, compares);
        if (fail_count == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // hang guard, well above the slowest divider pass
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            fail_count++;
            finish_test;
        end
    end
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready, halt_mode, load} = 8'h00;
        {awaddr, araddr, wdata} = 40'h0;
        ss_n = 1'b1;
        ext_sck = 1'b0;
        ext_mosi = 1'b1;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_reset;
        t_master;
        t_divider;
        t_fault;
        t_slave;
        finish_test;
    end
endmodule
